// File: hw/idp_pkg.sv
// constants and types shared by the two-wire bus controller files
package idp_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int SCL_LOW_NS = 5000;
    localparam int SCL_HIGH_NS = 5000;
    localparam int LOW_CYC = (SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int HIGH_CYC = (SCL_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] LOW_CNT = CNT_W'(LOW_CYC - 1);
    localparam logic [CNT_W-1:0] HIGH_CNT = CNT_W'(HIGH_CYC - 1);
    localparam logic [CNT_W-1:0] DATA_CNT = CNT_W'(LOW_CYC / 2);
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h0;
    localparam int CMD_W = 13;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int CMD_NACK_BIT = 11;
    localparam int CMD_NOBYTE_BIT = 12;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_ARB = 2;
    localparam int ST_BUS = 3;
    localparam int ST_OWN = 4;
    localparam int ST_REJ = 5;
    localparam int ST_RX_LSB = 8;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // ----------------------------------------------------------------
    // engine states
    // ----------------------------------------------------------------
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_START = 10'h002,
        S_LOW = 10'h004,
        S_WAITH = 10'h008,
        S_HIGH = 10'h010,
        S_RS1 = 10'h020,
        S_RS2 = 10'h040,
        S_STOP1 = 10'h080,
        S_STOP2 = 10'h100,
        S_STOP3 = 10'h200
    } idp_state_type;
endpackage

// File: hw/idp_line_if.sv
// synchronised bus line view passed from the line sampler to the engine
`timescale 1ns/1ps
`default_nettype none
interface idp_line_if;
    logic sda_s;
    logic scl_s;
    logic start_det;
    logic stop_det;
    logic bus_busy;
    modport src (output sda_s, scl_s, start_det, stop_det, bus_busy);
    modport snk (input sda_s, scl_s, start_det, stop_det, bus_busy);
endinterface
`default_nettype wire

// File: hw/idp_line_sync.sv
// line sampler: two-flop synchronisers and start/stop detection
`timescale 1ns/1ps
`default_nettype none
module idp_line_sync
    import idp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw bus lines
    input wire logic sda_i,
    input wire logic scl_i,
    // synchronised view
    idp_line_if.src ln
);
    typedef struct packed {
        logic sda_m;
        logic scl_m;
        logic sda_s;
        logic scl_s;
        logic sda_p;
        logic scl_p;
        logic busy;
    } idp_sync_type;

    idp_sync_type s_r;
    idp_sync_type s_nxt;
    logic start_w;
    logic stop_w;

    // ----------------------------------------------------------------
    // edge detection on synchronised samples
    // ----------------------------------------------------------------
    assign start_w = s_r.scl_s && s_r.scl_p && s_r.sda_p && !s_r.sda_s;
    assign stop_w = s_r.scl_s && s_r.scl_p && !s_r.sda_p && s_r.sda_s;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sda_m = sda_i;
        s_nxt.scl_m = scl_i;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.sda_p = s_r.sda_s;
        s_nxt.scl_p = s_r.scl_s;
        if (start_w) begin
            s_nxt.busy = 1'b1;
        end else if (stop_w) begin
            s_nxt.busy = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= 7'h7E;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ln.sda_s = s_r.sda_s;
    assign ln.scl_s = s_r.scl_s;
    assign ln.start_det = start_w;
    assign ln.stop_det = stop_w;
    assign ln.bus_busy = s_r.busy;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_busy_start: assert property (@(posedge clk) disable iff (!rst_n) start_w |=> s_r.busy)
        else $error("bus busy not set after start");
    a_busy_stop: assert property (@(posedge clk) disable iff (!rst_n) stop_w |=> !s_r.busy)
        else $error("bus busy not cleared after stop");
endmodule
`default_nettype wire

// File: hw/idp_ctrl.sv
// two-wire bus controller that addresses the device over its bus pins
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module idp_ctrl
    import idp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // bus lines, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    typedef struct packed {
        idp_state_type st;
        logic [CNT_W-1:0] cnt;
        logic [3:0] bit_n;
        logic [7:0] sh;
        logic samp;
        logic [CMD_W-1:0] cmd;
        logic cmd_pend;
        logic owner;
        logic scl_oe;
        logic sda_oe;
        logic nack;
        logic arb;
        logic rej;
        logic [7:0] rx;
        logic en;
        logic ack;
        logic [31:0] rdata;
    } idp_eng_type;

    idp_eng_type s_r;
    idp_eng_type s_nxt;
    idp_line_if ln ();
    logic lose;
    logic drv;
    logic rd;
    logic [31:0] stat_word;

    function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        sel = (a == ofs);
    endfunction

    idp_line_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sda_i(sda_i),
        .scl_i(scl_i),
        .ln(ln)
    );

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_comb begin
        stat_word = 32'h0;
        stat_word[ST_BUSY] = (s_r.st != S_IDLE) || s_r.cmd_pend;
        stat_word[ST_NACK] = s_r.nack;
        stat_word[ST_ARB] = s_r.arb;
        stat_word[ST_BUS] = ln.bus_busy;
        stat_word[ST_OWN] = s_r.owner;
        stat_word[ST_REJ] = s_r.rej;
        stat_word[ST_RX_LSB +: 8] = s_r.rx;
    end

    assign rd = s_r.cmd[CMD_READ_BIT];
    // pull-down value for the current bit; nack on the last read byte
    assign drv = (s_r.bit_n < ACK_BIT) ? (!rd && !s_r.sh[7]) : (rd && !s_r.cmd[CMD_NACK_BIT]);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        lose = 1'b0;
        s_nxt.ack = 1'b0;
        // register access: answer one cycle after the request
        if ((avs_read || avs_write) && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = 32'h0;
            if (sel(avs_address, OFS_CTRL)) begin
                s_nxt.rdata[CTRL_EN_BIT] = s_r.en;
            end else if (sel(avs_address, OFS_STAT)) begin
                s_nxt.rdata = stat_word;
            end
        end
        if (avs_write && s_r.ack) begin
            if (sel(avs_address, OFS_CTRL)) begin
                s_nxt.en = avs_writedata[CTRL_EN_BIT];
            end
            if (sel(avs_address, OFS_CMD)) begin
                if (s_r.en && s_r.st == S_IDLE && !s_r.cmd_pend) begin
                    s_nxt.cmd_pend = 1'b1;
                    s_nxt.cmd = avs_writedata[CMD_W-1:0];
                end else begin
                    s_nxt.rej = 1'b1;
                end
            end
            if (sel(avs_address, OFS_STAT)) begin
                if (avs_writedata[ST_ARB]) begin
                    s_nxt.arb = 1'b0;
                end
                if (avs_writedata[ST_REJ]) begin
                    s_nxt.rej = 1'b0;
                end
            end
        end
        // bus engine
        unique case (s_r.st)
            S_IDLE: begin
                // between bytes the owner parks SCL low
                s_nxt.scl_oe = s_r.owner;
                if (s_r.cmd_pend) begin
                    s_nxt.cmd_pend = 1'b0;
                    if (s_r.cmd[CMD_START_BIT]) begin
                        if (s_r.owner) begin
                            s_nxt.st = S_RS1;
                            s_nxt.cnt = LOW_CNT;
                        end else if (ln.sda_s && ln.scl_s && !ln.bus_busy) begin
                            s_nxt.st = S_START;
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.cnt = HIGH_CNT;
                        end else begin
                            lose = 1'b1;
                        end
                    end else if (!s_r.owner) begin
                        s_nxt.rej = 1'b1;
                    end else begin
                        s_nxt.scl_oe = 1'b1;
                        s_nxt.cnt = LOW_CNT;
                        s_nxt.bit_n = 4'h0;
                        s_nxt.sh = s_r.cmd[7:0];
                        if (s_r.cmd[CMD_NOBYTE_BIT]) begin
                            s_nxt.st = s_r.cmd[CMD_STOP_BIT] ? S_STOP1 : S_IDLE;
                        end else begin
                            s_nxt.st = S_LOW;
                        end
                    end
                end
            end
            S_START: begin
                s_nxt.sda_oe = 1'b1;
                if (s_r.cnt == '0) begin
                    // address byte follows the start
                    s_nxt.owner = 1'b1;
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.cnt = LOW_CNT;
                    s_nxt.bit_n = 4'h0;
                    s_nxt.sh = s_r.cmd[7:0];
                    if (s_r.cmd[CMD_NOBYTE_BIT]) begin
                        s_nxt.st = s_r.cmd[CMD_STOP_BIT] ? S_STOP1 : S_IDLE;
                    end else begin
                        s_nxt.st = S_LOW;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_LOW: begin
                s_nxt.scl_oe = 1'b1;
                if (s_r.cnt == DATA_CNT) begin
                    s_nxt.sda_oe = drv;
                end
                if (s_r.cnt == '0) begin
                    s_nxt.st = S_WAITH;
                    s_nxt.scl_oe = 1'b0;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_WAITH: begin
                if (ln.scl_s) begin
                    s_nxt.st = S_HIGH;
                    s_nxt.cnt = HIGH_CNT;
                    s_nxt.samp = ln.sda_s;
                end
            end
            S_HIGH: begin
                if (!rd && s_r.bit_n < ACK_BIT && !s_r.sda_oe && !ln.sda_s) begin
                    lose = 1'b1;
                end else if (!ln.scl_s || s_r.cnt == '0) begin
                    // shortest high period ends the bit
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.cnt = LOW_CNT;
                    s_nxt.sh = {s_r.sh[6:0], s_r.samp};
                    if (s_r.bit_n == ACK_BIT) begin
                        s_nxt.bit_n = 4'h0;
                        if (rd) begin
                            s_nxt.rx = s_r.sh;
                        end else begin
                            s_nxt.nack = s_r.samp;
                        end
                        s_nxt.st = s_r.cmd[CMD_STOP_BIT] ? S_STOP1 : S_IDLE;
                    end else begin
                        s_nxt.bit_n = s_r.bit_n + 4'h1;
                        s_nxt.st = S_LOW;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_RS1: begin
                s_nxt.scl_oe = 1'b1;
                if (s_r.cnt == DATA_CNT) begin
                    s_nxt.sda_oe = 1'b0;
                end
                if (s_r.cnt == '0) begin
                    s_nxt.st = S_RS2;
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.cnt = HIGH_CNT;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_RS2: begin
                if (!ln.scl_s) begin
                    s_nxt.cnt = HIGH_CNT;
                end else if (s_r.cnt == '0) begin
                    if (!ln.sda_s) begin
                        lose = 1'b1;
                    end else begin
                        s_nxt.st = S_START;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.cnt = HIGH_CNT;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_STOP1: begin
                s_nxt.scl_oe = 1'b1;
                if (s_r.cnt == DATA_CNT) begin
                    s_nxt.sda_oe = 1'b1;
                end
                if (s_r.cnt == '0) begin
                    s_nxt.st = S_STOP2;
                    s_nxt.scl_oe = 1'b0;
                    s_nxt.cnt = HIGH_CNT;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_STOP2: begin
                if (!ln.scl_s) begin
                    s_nxt.cnt = HIGH_CNT;
                end else if (s_r.cnt == '0) begin
                    s_nxt.st = S_STOP3;
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.owner = 1'b0;
                    s_nxt.cnt = HIGH_CNT;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            S_STOP3: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st = S_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            default: begin
                s_nxt.st = S_IDLE;
            end
        endcase
        // a stop we did not make means the bus was taken
        if (s_r.owner && ln.stop_det) begin
            lose = 1'b1;
        end
        if (lose) begin
            s_nxt.arb = 1'b1;
            s_nxt.st = S_IDLE;
            s_nxt.sda_oe = 1'b0;
            s_nxt.scl_oe = 1'b0;
            s_nxt.owner = 1'b0;
        end
        if (!s_r.en) begin
            s_nxt.st = S_IDLE;
            s_nxt.sda_oe = 1'b0;
            s_nxt.scl_oe = 1'b0;
            s_nxt.owner = 1'b0;
            s_nxt.cmd_pend = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            s_r.en <= CTRL_EN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
    assign avs_readdata = s_r.rdata;
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = s_r.sda_oe;
    assign scl_oe = s_r.scl_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_start_free: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_IDLE && s_nxt.st == S_START) |-> (ln.sda_s && ln.scl_s && !ln.bus_busy))
        else $error("start issued on a busy bus");
    a_sda_scl_low: assert property (@(posedge clk) disable iff (!rst_n)
        ((s_r.st == S_LOW || s_r.st == S_HIGH || s_r.st == S_WAITH) && s_r.en && !lose
            && s_nxt.sda_oe != s_r.sda_oe) |-> (s_r.st == S_LOW && s_r.scl_oe))
        else $error("sda moved while scl released");
    a_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_LOW) |-> s_r.scl_oe)
        else $error("scl not held low in low period");
    a_wait_scl: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_WAITH && !ln.scl_s && s_r.en && !lose) |=> (s_r.st == S_WAITH && !s_r.scl_oe))
        else $error("stretched scl not waited for");
    a_nine_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_HIGH) |-> (s_r.bit_n <= ACK_BIT))
        else $error("more than nine clocks in a byte");
    a_addr_first: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_START && s_nxt.st == S_LOW) |=> (s_r.bit_n == 4'h0 && s_r.sh == $past(s_r.cmd[7:0])))
        else $error("address byte not loaded after start");
    a_stop_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_STOP2 && s_nxt.st == S_STOP3) |=> (s_r.st == S_STOP3 && !s_r.sda_oe && !s_r.scl_oe))
        else $error("stop not a release of sda with scl high");
    a_rs_owner: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == S_RS1) |-> (s_r.owner && s_r.scl_oe))
        else $error("repeated start without owning the bus");
    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("register access not answered in time");
endmodule
`default_nettype wire

// File: tb/idp_target_model.sv
// behavioural target device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module idp_target_model #(
    parameter logic [6:0] OWN_ADDR = 7'h2A,
    parameter logic [7:0] TX_BYTE = 8'hC3,
    parameter int STRETCH_NS = 2000
) (
    // wired bus lines
    input wire logic sda,
    input wire logic scl,
    // pulls, high drives the line low
    output logic sda_pull,
    output logic scl_pull,
    // data register
    output logic [7:0] transfer_byte
);
    // ----------------------------------------------------------------
    // bit engine
    // ----------------------------------------------------------------
    int bitn = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic active = 1'b0;
    logic matched = 1'b0;
    logic rd = 1'b0;
    logic is_addr = 1'b0;
    logic nack = 1'b0;
    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        transfer_byte = 8'h00;
    end
    always @(negedge sda) begin
        if (scl) begin
            active = 1'b1;
            is_addr = 1'b1;
            matched = 1'b0;
            bitn = -1;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            active = 1'b0;
            matched = 1'b0;
            sda_pull = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (active && bitn < 8) sh = {sh[6:0], sda};
        else if (active) nack = sda;
    end
    always @(negedge scl) begin
        if (active) begin
            bitn = bitn + 1;
            sda_pull = 1'b0;
            if (bitn == 8) begin
                if (is_addr) begin
                    matched = (sh[7:1] == OWN_ADDR);
                    rd = sh[0];
                end else if (matched && !rd) begin
                    transfer_byte = sh;
                end
                sda_pull = matched && !(rd && !is_addr);
            end else if (bitn == 9) begin
                bitn = 0;
                is_addr = 1'b0;
                if (rd && nack) matched = 1'b0;
                tx = TX_BYTE;
                if (matched) begin
                    scl_pull = 1'b1;
                    #STRETCH_NS;
                    scl_pull = 1'b0;
                end
            end
            if (matched && rd && !is_addr && bitn < 8) sda_pull = !tx[7 - bitn];
        end
    end
endmodule
`default_nettype wire

// File: tb/idp_ctrl_tb_top.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module idp_ctrl_tb_top
    import idp_pkg::*;
;
    // ----------------------------------------------------------------
    // bench
    // ----------------------------------------------------------------
    typedef struct {
        logic [31:0] cmd;
        logic [31:0] mask;
        logic [31:0] stat;
        logic [7:0] tbyte;
    } idp_row_type;
    localparam logic [31:0] C_ST = 32'h1 << CMD_START_BIT;
    localparam logic [31:0] C_SP = 32'h1 << CMD_STOP_BIT;
    localparam logic [31:0] C_RD = 32'h1 << CMD_READ_BIT;
    localparam logic [31:0] C_NK = 32'h1 << CMD_NACK_BIT;
    localparam logic [31:0] C_NB = 32'h1 << CMD_NOBYTE_BIT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sda_o, sda_oe, scl_o, scl_oe, t_sda, t_scl;
    logic pull = 1'b0;
    logic [7:0] tbyte;
    logic [31:0] q;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n;
    wire sda_w;
    wire scl_w;
    idp_row_type rows [6] = '{
        '{C_ST | 32'h54, 32'hFFFF, 32'h0018, 8'h00},
        '{32'h5A, 32'hFFFF, 32'h0018, 8'h5A},
        '{C_ST | 32'h55, 32'hFFFF, 32'h0018, 8'h5A},
        '{C_RD | C_NK | C_SP, 32'hFFFD, 32'hC300, 8'h5A},
        '{C_ST | 32'h20, 32'hFFFF, 32'hC31A, 8'h5A},
        '{C_SP | C_NB, 32'hFFFD, 32'hC300, 8'h5A}
    };
    assign sda_w = !(sda_oe && !sda_o) && !t_sda && !pull;
    assign scl_w = !(scl_oe && !scl_o) && !t_scl;
    always #5 clk = ~clk;
    idp_ctrl idp_ctrl_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe));
    idp_target_model idp_target_model_i (.sda(sda_w), .scl(scl_w), .sda_pull(t_sda), .scl_pull(t_scl),
        .transfer_byte(tbyte));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // look at waitrequest where it is settled, then act on the edge that follows
        do begin
            @(negedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        @(posedge clk);
        if (k >= 50) n_mismatch++;
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            bus(1'b0, OFS_STAT, 32'h0, q);
            k++;
        end while (q[ST_BUSY] !== 1'b0 && k < 20000);
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h1, q);
        foreach (rows[i]) begin
            bus(1'b1, OFS_CMD, rows[i].cmd, q);
            wait_idle();
            check("stat", rows[i].stat, q & rows[i].mask);
            check("target byte", {24'h0, rows[i].tbyte}, {24'h0, tbyte});
            $display("test row %0d done", i);
        end
        bus(1'b1, OFS_CMD, C_ST | 32'hFE, q);
        n = 0;
        while (sda_oe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        pull <= 1'b1;
        wait_idle();
        pull <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0, q);
        check("arb stat", 32'h04, q & 32'h3D);
        check("arb lines", 32'h0, {30'h0, sda_oe, scl_oe});
        bus(1'b1, OFS_STAT, 32'h04, q);
        bus(1'b0, OFS_STAT, 32'h0, q);
        check("arb clear", 32'h0, q & 32'h04);
        $display("test arbitration done");
        bus(1'b1, OFS_CMD, C_ST | 32'h54, q);
        repeat (1500) @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("lines in reset", 32'h0, {30'h0, sda_oe, scl_oe});
        rst_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0, q);
        check("ctrl", 32'h0, q);
        bus(1'b1, OFS_CMD, C_ST | 32'h54, q);
        bus(1'b0, OFS_STAT, 32'h0, q);
        check("stat rej", 32'h20, q & 32'h3F);
        bus(1'b1, OFS_STAT, 32'h20, q);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
        bus(1'b0, 4'hC, 32'h0, q);
        check("unmapped", 32'h0, q);
        bus(1'b0, OFS_STAT, 32'h0, q);
        check("stat clear", 32'h0, q & 32'h3F);
        $display("test reset done");
        complete_run();
    end
endmodule
`default_nettype wire
